// ==== rtl/card_coupler_defs.svh ====
// offsets, field positions, codes and reset values of the write byte decoder
// assumes a single clock; included by the decoder module only
`ifndef CARD_COUPLER_DEFS_SVH
`define CARD_COUPLER_DEFS_SVH

// ***********************************************************************
// write byte fields
// ***********************************************************************
`define CC_BYTE_BITS      4'h8
`define CC_RST_BIT_INDEX  4'h3
`define CC_CMD_MSB        7
`define CC_CMD_LSB        5
`define CC_DATA_MSB       4
`define CC_DATA_LSB       0

// ***********************************************************************
// command and data codes
// ***********************************************************************
`define CC_CMD_SYNC       3'h6
`define CC_CMD_CFG        3'h5
`define CC_CMD_RFU        3'h7
`define CC_CFG_DET_NO     5'h00
`define CC_CFG_DET_NC     5'h01
`define CC_CFG_SPECIAL    5'h02
`define CC_CFG_NORMAL     5'h03

// ***********************************************************************
// reset values
// ***********************************************************************
`define CC_RST_SUPPLY     2'h0
`define CC_RST_CLK_SEL    2'h0
`define CC_RST_LEVEL      1'h0
`define CC_RST_POLARITY   1'h0
`define CC_RST_SPECIAL    1'h0

`endif

// ==== rtl/card_coupler_pkg.sv ====
// types shared by the write byte decoder
// assumes nothing of its surroundings
package card_coupler_pkg;

   typedef enum logic [1:0]
   {
      supply_off   = 2'h0,
      supply_1v8   = 2'h1,
      supply_3v0   = 2'h2,
      supply_5v0   = 2'h3
   } supply_e;

   typedef enum logic [1:0]
   {
      clk_low      = 2'h0,
      clk_div1     = 2'h1,
      clk_div2     = 2'h2,
      clk_div4     = 2'h3
   } clk_sel_e;

   typedef enum logic [1:0]
   {
      st_idle      = 2'h0,
      st_shift     = 2'h1,
      st_overrun   = 2'h2
   } port_state_e;

   // pins after the synchroniser
   typedef struct packed
   {
      logic sel_high;
      logic sel_low;
      logic clk_in;
      logic cs_n;
      logic mosi;
      logic sclk;
   } pins_s;

   // settings applied at the end of a full byte
   typedef struct packed
   {
      supply_e  supply;
      clk_sel_e clk_sel;
      logic     sync_mode;
      logic     sync_clk;
      logic     sync_data;
      logic     aux_first;
      logic     aux_second;
      logic     det_closed;
      logic     special_mode;
   } settings_s;

endpackage

// ==== rtl/pin_sync.sv ====
// three flip-flop synchroniser with agreement filter for asynchronous pins
// assumes a synchronous active low reset copy from the caller
`timescale 1ns/1ps
`default_nettype none

module pin_sync
#(
   parameter int               WIDTH = 6,
   parameter logic [WIDTH-1:0] IDLE  = '0
)
(
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_pins,
   output logic      [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] level_r;
   logic [WIDTH-1:0] level_nxt;

   // a bit only changes once stages two and three agree
   always_comb
   begin
      level_nxt = level_r;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (s2_r[i] == s3_r[i])
         begin
            level_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         // start at the pin's idle level, so no false edge follows reset
         s1_r    <= IDLE;
         s2_r    <= IDLE;
         s3_r    <= IDLE;
         level_r <= IDLE;
      end
      else
      begin
         s1_r    <= i_pins;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         level_r <= level_nxt;
      end
   end

   assign o_level = level_r;

endmodule

`default_nettype wire

// ==== rtl/card_coupler_write_decoder.sv ====
// serial write byte decoder of a smart card coupler
// assumes serial pins and the card input clock are asynchronous to i_mclk
`timescale 1ns/1ps
`default_nettype none
`include "card_coupler_defs.svh"

// Function
// - byte holds three command bits on top and five data bits below
// - serial activity only counts while chip select is low
// - card reset output follows data bit four as soon as it arrives
// - ordinary commands: data bits one and zero choose card supply level
// - ordinary commands: data bits three and two choose card clock source
// - command 110: bits one and zero drive the two auxiliary lines
// - command 110: bit three drives card clock, bit two card data
// - command 101: data 00000 detect normally open, 00001 normally closed
// - command 101: data 00010 special port mode, 00011 normal mode
// - bank commands compared with the two address select pins
module card_coupler_write_decoder
(
   input  wire logic                        i_mclk,
   input  wire logic                        i_resetn,
   input  wire logic                        i_sclk,
   input  wire logic                        i_mosi,
   input  wire logic                        i_cs_n,
   input  wire logic                        i_clk_in,
   input  wire logic                        i_address_select_pin_low,
   input  wire logic                        i_address_select_pin_high,
   output logic                             o_card_reset_out,
   output card_coupler_pkg::supply_e        o_card_supply_level,
   output logic                             o_card_clock_out,
   output logic                             o_card_data_line,
   output logic                             o_card_data_line_oe,
   output logic                             o_aux_line_first,
   output logic                             o_aux_line_second,
   output logic                             o_detect_switch_polarity,
   output logic                             o_serial_special_mode
);

   // ***********************************************************************
   // reset release
   // ***********************************************************************
   logic rst_s1_r;
   logic rst_n_r;

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // ***********************************************************************
   // pin synchronisers
   // ***********************************************************************
   card_coupler_pkg::pins_s pins_raw;
   card_coupler_pkg::pins_s pins;
   logic [5:0]              pins_level;

   assign pins_raw = '{sel_high : i_address_select_pin_high,
                       sel_low  : i_address_select_pin_low,
                       clk_in   : i_clk_in,
                       cs_n     : i_cs_n,
                       mosi     : i_mosi,
                       sclk     : i_sclk};

   pin_sync #(.WIDTH(6), .IDLE(6'h04)) u_pin_sync // chip select idles high
   (
      .i_mclk  (i_mclk),
      .i_rst_n (rst_n_r),
      .i_pins  (pins_raw),
      .o_level (pins_level)
   );

   assign pins = card_coupler_pkg::pins_s'(pins_level);

   // ***********************************************************************
   // decode of a complete byte
   // ***********************************************************************
   // bank codes 000..011 only hit when b6:b5 match the select pins
   function automatic logic addressed(input logic [2:0] cmd,
                                      input logic       sel_high,
                                      input logic       sel_low);
      addressed = cmd[2] | (cmd[1:0] == {sel_high, sel_low});
   endfunction

   function automatic card_coupler_pkg::settings_s apply_byte(
      input card_coupler_pkg::settings_s cur,
      input logic [7:0]                  wbyte);
      logic [2:0] cmd;
      logic [4:0] dat;
      card_coupler_pkg::settings_s s;
      cmd = wbyte[`CC_CMD_MSB:`CC_CMD_LSB];
      dat = wbyte[`CC_DATA_MSB:`CC_DATA_LSB];
      s   = cur;
      case (cmd)
         `CC_CMD_SYNC:
         begin
            s.sync_mode  = 1'b1;
            s.aux_first  = dat[1];
            s.aux_second = dat[0];
            s.sync_clk   = dat[3];
            s.sync_data  = dat[2];
         end
         `CC_CMD_CFG:
         begin
            case (dat)
               `CC_CFG_DET_NO:  s.det_closed   = 1'b0;
               `CC_CFG_DET_NC:  s.det_closed   = 1'b1;
               `CC_CFG_SPECIAL: s.special_mode = 1'b1;
               `CC_CFG_NORMAL:  s.special_mode = 1'b0;
               default:         s              = cur;
            endcase
         end
         `CC_CMD_RFU:
         begin
            s = cur;
         end
         default:
         begin
            s.sync_mode = 1'b0;
            s.supply    = card_coupler_pkg::supply_e'(dat[1:0]);
            s.clk_sel   = card_coupler_pkg::clk_sel_e'(dat[3:2]);
         end
      endcase
      apply_byte = s;
   endfunction

   // ***********************************************************************
   // serial port
   // ***********************************************************************
   card_coupler_pkg::port_state_e state_r;
   card_coupler_pkg::port_state_e state_nxt;
   card_coupler_pkg::settings_s   set_r;
   card_coupler_pkg::settings_s   set_nxt;
   logic [7:0]                    shift_r;
   logic [7:0]                    shift_nxt;
   logic [3:0]                    cnt_r;
   logic [3:0]                    cnt_nxt;
   logic                          sclk_d_r;
   logic                          cs_d_r;
   logic                          reset_r;
   logic                          reset_nxt;
   logic                          sclk_rise;
   logic                          cs_rise;

   assign sclk_rise = pins.sclk & ~sclk_d_r;
   assign cs_rise   = pins.cs_n & ~cs_d_r;

   always_comb
   begin
      state_nxt = state_r;
      set_nxt   = set_r;
      shift_nxt = shift_r;
      cnt_nxt   = cnt_r;
      reset_nxt = reset_r;
      case (state_r)
         card_coupler_pkg::st_idle:
         begin
            cnt_nxt = 4'h0;
            if (!pins.cs_n)
            begin
               state_nxt = card_coupler_pkg::st_shift;
            end
         end
         card_coupler_pkg::st_shift:
         begin
            if (cs_rise)
            begin
               state_nxt = card_coupler_pkg::st_idle;
               // partial bytes change no setting; only the card reset has already taken b4
               if (cnt_r == `CC_BYTE_BITS &&
                   addressed(shift_r[7:5], pins.sel_high, pins.sel_low))
               begin
                  set_nxt = apply_byte(set_r, shift_r);
               end
            end
            else if (sclk_rise)
            begin
               if (cnt_r == `CC_BYTE_BITS)
               begin
                  state_nxt = card_coupler_pkg::st_overrun;
               end
               else
               begin
                  shift_nxt = {shift_r[6:0], pins.mosi};
                  cnt_nxt   = cnt_r + 4'h1;
                  if (cnt_r == `CC_RST_BIT_INDEX)
                  begin
                     // host keeps b4 low when addressing, reset shows it now
                     reset_nxt = pins.mosi;
                  end
               end
            end
         end
         card_coupler_pkg::st_overrun:
         begin
            if (cs_rise)
            begin
               state_nxt = card_coupler_pkg::st_idle;
            end
         end
         default:
         begin
            state_nxt = card_coupler_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         state_r  <= card_coupler_pkg::st_idle;
         set_r    <= '{supply       : card_coupler_pkg::supply_e'(`CC_RST_SUPPLY),
                       clk_sel      : card_coupler_pkg::clk_sel_e'(`CC_RST_CLK_SEL),
                       sync_mode    : `CC_RST_LEVEL,
                       sync_clk     : `CC_RST_LEVEL,
                       sync_data    : `CC_RST_LEVEL,
                       aux_first    : `CC_RST_LEVEL,
                       aux_second   : `CC_RST_LEVEL,
                       det_closed   : `CC_RST_POLARITY,
                       special_mode : `CC_RST_SPECIAL};
         shift_r  <= 8'h00;
         cnt_r    <= 4'h0;
         sclk_d_r <= 1'b0;
         cs_d_r   <= 1'b1;
         reset_r  <= `CC_RST_LEVEL;
      end
      else
      begin
         state_r  <= state_nxt;
         set_r    <= set_nxt;
         shift_r  <= shift_nxt;
         cnt_r    <= cnt_nxt;
         sclk_d_r <= pins.sclk;
         cs_d_r   <= pins.cs_n;
         reset_r  <= reset_nxt;
      end
   end

   // ***********************************************************************
   // card clock divider
   // ***********************************************************************
   // input clock is sampled, so it must stay well below a quarter of i_mclk
   logic [1:0] div_r;
   logic [1:0] div_nxt;
   logic       clkin_d_r;
   logic       cclk_r;
   logic       cclk_nxt;

   always_comb
   begin
      div_nxt = div_r;
      if (pins.clk_in && !clkin_d_r)
      begin
         div_nxt = div_r + 2'h1;
      end
      if (set_r.sync_mode)
      begin
         cclk_nxt = set_r.sync_clk;
      end
      else
      begin
         case (set_r.clk_sel)
            card_coupler_pkg::clk_low:  cclk_nxt = 1'b0;
            card_coupler_pkg::clk_div1: cclk_nxt = pins.clk_in;
            card_coupler_pkg::clk_div2: cclk_nxt = div_r[0];
            card_coupler_pkg::clk_div4: cclk_nxt = div_r[1];
            default:                    cclk_nxt = 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         div_r     <= 2'h0;
         clkin_d_r <= 1'b0;
         cclk_r    <= `CC_RST_LEVEL;
      end
      else
      begin
         div_r     <= div_nxt;
         clkin_d_r <= pins.clk_in;
         cclk_r    <= cclk_nxt;
      end
   end

   // ***********************************************************************
   // outputs
   // ***********************************************************************
   assign o_card_reset_out         = reset_r;
   assign o_card_supply_level      = set_r.supply;
   assign o_card_clock_out         = cclk_r;
   assign o_card_data_line         = set_r.sync_data;
   assign o_card_data_line_oe      = set_r.sync_mode;
   assign o_aux_line_first         = set_r.aux_first;
   assign o_aux_line_second        = set_r.aux_second;
   assign o_detect_switch_polarity = set_r.det_closed;
   assign o_serial_special_mode    = set_r.special_mode;

endmodule

`default_nettype wire

// ==== sim/card_coupler_host.sv ====
// host side model: drives the serial write port of the decoder
// assumes the caller gives the system clock; drives on its falling edge
`timescale 1ns/1ps
`default_nettype none

module card_coupler_host
(
   input  wire logic i_mclk,
   output logic      o_sclk,
   output logic      o_mosi,
   output logic      o_cs_n
);
   // *****************
   // serial transfer
   // *****************
   initial
   begin
      o_sclk = 1'b0;
      o_mosi = 1'b0;
      o_cs_n = 1'b1;
   end

   task automatic wt(input int n);
      repeat (n) @(negedge i_mclk);
   endtask

   // b7 first: command on top, data below, n bits per select, b7 again after b0
   // the caller keeps b4 low on addressing bytes, reset sees it at once
   // sel low leaves the select high, to show junk clocking
   task automatic send(input logic [7:0] v, input int n, input bit sel);
      o_cs_n = !sel;
      wt(8);
      for (int i = 0; i < n; i++)
      begin
         o_mosi = v[7 - (i % 8)];
         wt(8);
         o_sclk = 1'b1;
         wt(8);
         o_sclk = 1'b0;
      end
      wt(8);
      o_cs_n = 1'b1;
      // released line: show the inverse, not a stale level
      o_mosi = !o_mosi;
      wt(24);
   endtask
endmodule

`default_nettype wire

// ==== sim/card_coupler_write_decoder_chk.sv ====
// port checker of the write byte decoder
// assumes one clock; serial levels last at least four clocks
`timescale 1ns/1ps
`default_nettype none

module card_coupler_write_decoder_chk
(
   input wire logic                       i_mclk,
   input wire logic                       i_resetn,
   input wire logic                       i_sclk,
   input wire logic                       i_mosi,
   input wire logic                       i_cs_n,
   input wire logic                       i_address_select_pin_low,
   input wire logic                       i_address_select_pin_high,
   input wire logic                       o_card_reset_out,
   input wire logic [1:0]                 o_card_supply_level,
   input wire logic                       o_card_clock_out,
   input wire logic                       o_card_data_line,
   input wire logic                       o_card_data_line_oe,
   input wire logic                       o_aux_line_first,
   input wire logic                       o_aux_line_second,
   input wire logic                       o_detect_switch_polarity,
   input wire logic                       o_serial_special_mode
);
   // *****************
   // byte tracking
   // *****************
   logic       sclk_r, cs_r;
   logic [3:0] cnt_r, cnt_nxt, hi_r, hi_nxt;
   logic [7:0] sh_r, sh_nxt;
   wire logic  edge_s = i_sclk && !sclk_r;
   wire logic  rise4 = !i_cs_n && edge_s && cnt_r == 4'h3;
   wire logic  done = i_cs_n && !cs_r && cnt_r == 4'h8;
   wire logic  part = i_cs_n && !cs_r && cnt_r != 4'h8 && cnt_r != 4'h0;
   wire logic [2:0] cmd = sh_r[7:5];
   wire logic [4:0] dat = sh_r[4:0];
   wire logic  hit = cmd[1:0] == {i_address_select_pin_high, i_address_select_pin_low};
   wire logic  ord = cmd < 3'h5 && (cmd[2] || hit);

   always_comb
   begin
      sh_nxt = sh_r;
      cnt_nxt = cnt_r;
      hi_nxt = 4'h0;
      if (i_cs_n)
      begin
         cnt_nxt = 4'h0;
         hi_nxt = (hi_r == 4'hf) ? hi_r : hi_r + 4'h1;
      end
      else if (edge_s)
      begin
         sh_nxt = {sh_r[6:0], i_mosi};
         cnt_nxt = (cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sclk_r <= 1'b0;
         cs_r <= 1'b1;
         cnt_r <= 4'h0;
         hi_r <= 4'h0;
         sh_r <= 8'h00;
      end
      else
      begin
         sclk_r <= i_sclk;
         cs_r <= i_cs_n;
         cnt_r <= cnt_nxt;
         hi_r <= hi_nxt;
         sh_r <= sh_nxt;
      end
   end

   // *****************
   // assertions
   // *****************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   // settings must not move for a while: decode window is a few clocks
   sequence s_held;
      ##4 $stable({o_card_supply_level, o_aux_line_first, o_aux_line_second,
         o_card_data_line_oe, o_detect_switch_polarity, o_serial_special_mode}) [*8];
   endsequence

   a_quiet_deselected:
      assert property (hi_r == 4'hf |-> $stable({o_card_reset_out, o_card_supply_level,
         o_aux_line_first, o_detect_switch_polarity, o_serial_special_mode}))
      else $error("output moved while deselected");
   a_reset_follows:
      assert property (rise4 |=> ##[2:10] o_card_reset_out == sh_r[0])
      else $error("card reset did not follow bit four");
   a_supply_set:
      assert property (done && ord |-> ##[2:14] o_card_supply_level == dat[1:0])
      else $error("supply level not applied");
   a_clock_held_low:
      assert property (done && ord && dat[3:2] == 2'h0 |-> ##14 (!o_card_clock_out) [*4])
      else $error("card clock not held low");
   a_aux_levels:
      assert property (done && cmd == 3'h6 |->
         ##[2:14] {o_aux_line_first, o_aux_line_second} == dat[1:0])
      else $error("aux lines wrong");
   a_sync_levels:
      assert property (done && cmd == 3'h6 |-> ##[2:14]
         {o_card_clock_out, o_card_data_line, o_card_data_line_oe} == {dat[3:2], 1'b1})
      else $error("sync clock or data wrong");
   a_detect_set:
      assert property (done && cmd == 3'h5 && dat[4:1] == 4'h0 |->
         ##[2:14] o_detect_switch_polarity == dat[0])
      else $error("detect polarity wrong");
   a_mode_set:
      assert property (done && cmd == 3'h5 && dat[4:1] == 4'h1 |->
         ##[2:14] o_serial_special_mode == !dat[0])
      else $error("port mode wrong");
   a_bank_ignored:
      assert property (done && !cmd[2] && !hit |-> s_held)
      else $error("unaddressed byte applied");
   a_reserved_held:
      assert property (done && (cmd == 3'h7 || (cmd == 3'h5 && dat > 5'h5)) |-> s_held)
      else $error("reserved code changed a setting");
   a_partial_held:
      assert property (part |-> s_held)
      else $error("partial byte changed a setting");
endmodule

bind card_coupler_write_decoder card_coupler_write_decoder_chk chk (.i_mclk, .i_resetn,
   .i_sclk, .i_mosi, .i_cs_n, .i_address_select_pin_low, .i_address_select_pin_high,
   .o_card_reset_out, .o_card_supply_level, .o_card_clock_out, .o_card_data_line,
   .o_card_data_line_oe, .o_aux_line_first, .o_aux_line_second,
   .o_detect_switch_polarity, .o_serial_special_mode);

`default_nettype wire

// ==== sim/card_coupler_write_decoder_test.sv ====
// self-checking bench of the write byte decoder
// assumes the host model for serial traffic; card clock in at 25 MHz
`timescale 1ns/1ps
`default_nettype none

module card_coupler_write_decoder_test;
   // *****************
   // harness
   // *****************
   logic i_mclk = 0, i_resetn = 0, i_clk_in = 0, sel_lo = 0, sel_hi = 0;
   wire  sclk, mosi, cs_n;
   logic rst_o, clk_o, dat_o, oe_o, a1, a2, det, spm;
   card_coupler_pkg::supply_e sup;
   int   err_count = 0, checked = 0, cycles = 0;

   always #2 i_mclk = ~i_mclk;
   always #20 i_clk_in = ~i_clk_in;

   card_coupler_host host (.i_mclk(i_mclk), .o_sclk(sclk), .o_mosi(mosi), .o_cs_n(cs_n));

   card_coupler_write_decoder dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_sclk(sclk),
      .i_mosi(mosi), .i_cs_n(cs_n), .i_clk_in(i_clk_in), .i_address_select_pin_low(sel_lo),
      .i_address_select_pin_high(sel_hi), .o_card_reset_out(rst_o),
      .o_card_supply_level(sup), .o_card_clock_out(clk_o), .o_card_data_line(dat_o),
      .o_card_data_line_oe(oe_o), .o_aux_line_first(a1), .o_aux_line_second(a2),
      .o_detect_switch_polarity(det), .o_serial_special_mode(spm));

   task check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // card clock rises over 800 ns, tolerance one for phase
   task clk_rate(input int e);
      int   n;
      logic p;
      n = 0;
      p = clk_o;
      repeat (200)
      begin
         @(negedge i_mclk);
         if (clk_o && !p)
            n++;
         p = clk_o;
      end
      check({7'h0, n >= e - 1 && n <= e + 1}, 8'h01);
   endtask

   always @(posedge i_mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         close_out();
      end
   end

   // *****************
   // tests
   // *****************
   initial
   begin
      logic [1:0] q;
      logic       det_e, spm_e;
      det_e = 1'b0;
      spm_e = 1'b0;
      repeat (16) @(negedge i_mclk);
      i_resetn = 1'b1;
      repeat (12) @(negedge i_mclk);
      check({sup, rst_o, dat_o, oe_o, a1, a2, det}, 8'h00);
      check({6'h0, clk_o, spm}, 8'h00);
      $display("test reset done");

      for (int k = 0; k < 4; k++)
      begin
         q = k[1:0];
         host.send({3'b100, 1'b0, q, q}, 8, 1'b1);
         check({6'h0, sup}, {6'h0, q});
         clk_rate(k == 0 ? 0 : 20 >> (k - 1));
      end
      $display("test supply and clock done");

      sel_hi = 1'b1;
      host.send(8'b010_00001, 8, 1'b1);
      check({6'h0, sup}, 8'h01);
      host.send(8'b001_00011, 8, 1'b1);
      check({6'h0, sup}, 8'h01);
      sel_lo = 1'b1;
      host.send(8'b010_00011, 8, 1'b1);
      check({6'h0, sup}, 8'h01);
      $display("test bank select done");

      host.send(8'b100_10011, 4, 1'b1);
      check({5'h0, rst_o, sup}, 8'h05);
      host.send(8'b100_00011, 9, 1'b1);
      check({6'h0, sup}, 8'h01);
      host.send(8'b100_00011, 8, 1'b0);
      check({6'h0, sup}, 8'h01);
      host.send(8'b100_00000, 8, 1'b1);
      check({5'h0, rst_o, sup}, 8'h00);
      $display("test partial and deselect done");

      host.send(8'b110_01010, 8, 1'b1);
      check({3'h0, a1, a2, clk_o, dat_o, oe_o}, 8'b000_10101);
      host.send(8'b110_00101, 8, 1'b1);
      check({3'h0, a1, a2, clk_o, dat_o, oe_o}, 8'b000_01011);
      $display("test sync lines done");

      for (int k = 0; k < 4; k++)
      begin
         q = k[1:0];
         host.send({3'b101, 3'b000, q}, 8, 1'b1);
         if (q[1])
            spm_e = !q[0];
         else
            det_e = q[0];
         check({6'h0, det, spm}, {6'h0, det_e, spm_e});
      end
      $display("test detect and mode done");

      host.send(8'b111_11111, 8, 1'b1);
      host.send(8'b101_01111, 8, 1'b1);
      check({4'h0, a1, a2, det, spm}, {6'b000001, det_e, spm_e});
      $display("test reserved done");
      close_out();
   end
endmodule

`default_nettype wire
